// >>> sspt_shift_port.sv
// serial shift port: register slave, shift engine and pin control
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "sspt_map.svh"

module sspt_shift_port (
  input  wire logic                    clk,
  input  wire logic                    nrst,
  input  wire logic [`SSPT_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [7:0]              reg_rdata,
  input  wire logic                    serial_in,
  input  wire logic                    shift_clock_pin_in,
  output logic                         shift_clock_pin_out,
  output logic                         shift_clock_pin_oe,
  output logic                         port_pin_serial_out,
  output logic                         port_pin_serial_out_oe,
  output logic                         done_irq
);

  // reset release
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // pin synchronisers
  logic si_meta_q;
  logic si_q;
  logic sck_meta_q;
  logic sck_sync_q;
  logic sck_prev_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      si_meta_q  <= 1'b0;
      si_q       <= 1'b0;
      sck_meta_q <= 1'b0;
      sck_sync_q <= 1'b0;
      sck_prev_q <= 1'b0;
    end else begin
      si_meta_q  <= serial_in;
      si_q       <= si_meta_q;
      sck_meta_q <= shift_clock_pin_in;
      sck_sync_q <= sck_meta_q;
      sck_prev_q <= sck_sync_q;
    end
  end

  // configuration and state registers
  sspt_pkg::sspt_cfg_s   cfg_q;
  sspt_pkg::sspt_cfg_s   cfg_d;
  sspt_pkg::sspt_state_e state_q;
  sspt_pkg::sspt_state_e state_d;
  logic [7:0]            sr_q;
  logic [7:0]            sr_d;
  logic [3:0]            edge_cnt_q;
  logic [3:0]            edge_cnt_d;
  logic                  done_q;
  logic                  done_d;
  logic                  so_q;
  logic                  so_d;
  logic [1:0]            cap_q;
  logic [1:0]            cap_d;
  logic                  late_cap;

  // address decode
  logic wr_ctrl;
  logic wr_status;
  logic wr_cfg;
  logic wr_data;
  logic wr_shift;

  assign wr_ctrl   = reg_wr && (reg_addr == `SSPT_REG_CTRL);
  assign wr_status = reg_wr && (reg_addr == `SSPT_REG_STATUS);
  assign wr_cfg    = reg_wr && (reg_addr == `SSPT_REG_PORT_CFG);
  assign wr_data   = reg_wr && (reg_addr == `SSPT_REG_PORT_DATA);
  assign wr_shift  = reg_wr && (reg_addr == `SSPT_REG_SHIFT);

  logic sw_busy_set;
  logic sw_busy_clr;
  logic sw_done_clr;

  assign sw_busy_set = wr_status && reg_wdata[`SSPT_STAT_BUSY_BIT];
  assign sw_busy_clr = wr_status && !reg_wdata[`SSPT_STAT_BUSY_BIT];
  assign sw_done_clr = wr_status && reg_wdata[`SSPT_STAT_DONE_BIT];

  // mode selection
  logic busy;
  logic active;
  logic master;
  logic eff_alt;

  assign busy   = (state_q == sspt_pkg::SSPT_SHIFT);
  // [R3] enable gates all activity
  assign active = cfg_q.serial_enable_select && busy;
  // [R2] internal clock is master
  assign master = cfg_q.clk_cfg;
  // [R21] phase xor idle polarity
  assign eff_alt = cfg_q.clock_phase_select ^ cfg_q.idle_pol;

  // master clock generator
  logic gen_sck;
  logic gen_tick;
  logic gen_run;

  // [R8] clock only runs for a transfer
  assign gen_run = active && master;

  sspt_sck_gen u_sck_gen (
    .clk      (clk),
    .rst_n    (rst_n),
    .run      (gen_run),
    .rate     (cfg_q.rate),
    .idle_lvl (cfg_q.idle_pol),
    .sck_q    (gen_sck),
    .tick     (gen_tick)
  );

  // clock edges seen by the shift engine
  logic rise_w;
  logic fall_w;
  logic edge_w;
  logic in_edge;
  logic out_edge;
  logic last_edge;

  // [R2] edges from own clock or from the pin
  // [R15] slave edges assume busy was set in the idle phase
  assign rise_w = master ? (gen_tick && !gen_sck)
                         : (sck_sync_q && !sck_prev_q);
  assign fall_w = master ? (gen_tick && gen_sck)
                         : (!sck_sync_q && sck_prev_q);
  assign edge_w = active && (rise_w || fall_w);

  // [R16] normal: sample rising, output falling
  // [R17] alternate: sample falling, output rising
  assign in_edge  = active && (eff_alt ? fall_w : rise_w);
  assign out_edge = active && (eff_alt ? rise_w : fall_w);

  // own clock edges lead the synchronised pin by two cycles, so a master
  // sample is patched two cycles later with the bit seen at the edge
  assign cap_d    = wr_shift ? 2'h0 : {cap_q[0], in_edge && master};
  assign late_cap = cap_q[1];

  // [R9] sixteenth edge ends eighth pulse
  assign last_edge = edge_w && (edge_cnt_q == `SSPT_EDGES_LAST);

  // configuration next value
  always_comb begin
    cfg_d = cfg_q;
    if (wr_ctrl) begin
      cfg_d.serial_enable_select = reg_wdata[`SSPT_CTRL_EN_BIT];
      cfg_d.rate = {reg_wdata[`SSPT_CTRL_RATE_HI],
                    reg_wdata[`SSPT_CTRL_RATE_LO]};
      cfg_d.irq_en = reg_wdata[`SSPT_CTRL_IRQEN_BIT];
    end
    if (wr_cfg) begin
      // [R12] out and clock pin config
      cfg_d.out_cfg = reg_wdata[`SSPT_CFG_OUT_BIT];
      cfg_d.clk_cfg = reg_wdata[`SSPT_CFG_CLK_BIT];
      // [R19] phase select at bit 6
      cfg_d.clock_phase_select = reg_wdata[`SSPT_CFG_PHASE_BIT];
    end
    if (wr_data) begin
      // [R18] idle level at bit 5
      cfg_d.idle_pol = reg_wdata[`SSPT_DATA_IDLE_BIT];
    end
  end

  // transfer state machine
  always_comb begin
    state_d    = state_q;
    edge_cnt_d = edge_cnt_q;
    case (state_q)
      sspt_pkg::SSPT_IDLE: begin
        // [R5] busy set starts shifting
        if (sw_busy_set) begin
          state_d    = sspt_pkg::SSPT_SHIFT;
          edge_cnt_d = 4'h0;
        end
      end
      sspt_pkg::SSPT_SHIFT: begin
        if (edge_w) begin
          edge_cnt_d = edge_cnt_q + 4'h1;
        end
        if (sw_busy_set && last_edge) begin
          // a fresh start in the finishing cycle wins
          edge_cnt_d = 4'h0;
        end else if (sw_busy_clr) begin
          // [R6] software stop at once
          state_d = sspt_pkg::SSPT_IDLE;
        end else if (last_edge) begin
          // [R5] hardware clears busy
          state_d = sspt_pkg::SSPT_IDLE;
        end
      end
      default: begin
        state_d = sspt_pkg::SSPT_IDLE;
      end
    endcase
  end

  // shift register and serial output bit
  always_comb begin
    sr_d = sr_q;
    so_d = so_q;
    if (wr_shift) begin
      // [R14] software load; caller keeps to idle phase
      sr_d = reg_wdata;
    end else if (in_edge && late_cap) begin
      // [R16] [R22] patch previous bit while shifting
      sr_d = {sr_q[6:1], si_q, si_q};
    end else if (in_edge) begin
      // [R1] [R22] msb first, new bit at lsb
      sr_d = {sr_q[6:0], si_q};
    end else if (late_cap) begin
      sr_d = {sr_q[7:1], si_q};
    end
    if (!busy) begin
      so_d = sr_q[7];
    end else if (out_edge) begin
      // [R22] next msb onto the pin
      so_d = sr_q[7];
    end
  end

  // completion flag, set wins only over a clear written with busy set
  always_comb begin
    done_d = done_q;
    if (sw_done_clr) begin
      done_d = 1'b0;
    end
    if (last_edge && !sw_busy_clr) begin
      done_d = 1'b1;
    end
  end

  // [R20] phase select resets cleared
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= '0;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= sspt_pkg::SSPT_IDLE;
      edge_cnt_q <= 4'h0;
    end else begin
      state_q    <= state_d;
      edge_cnt_q <= edge_cnt_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sr_q  <= `SSPT_SHIFT_RST;
      so_q  <= 1'b0;
      cap_q <= 2'h0;
    end else begin
      sr_q  <= sr_d;
      so_q  <= so_d;
      cap_q <= cap_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else begin
      done_q <= done_d;
    end
  end

  // interrupt request
  logic irq_q;

  // [R7] completion gated by enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= done_d && cfg_d.irq_en;
    end
  end

  // pin drivers
  logic so_oe_q;
  logic sck_oe_q;

  // [R3] [R12] outputs routed only when enabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      so_oe_q  <= 1'b0;
      sck_oe_q <= 1'b0;
    end else begin
      so_oe_q  <= cfg_d.serial_enable_select && cfg_d.out_cfg;
      sck_oe_q <= cfg_d.serial_enable_select && cfg_d.clk_cfg;
    end
  end

  // read path
  logic [7:0] rmux;
  logic       sck_level;

  assign sck_level = master ? gen_sck : sck_sync_q;

  always_comb begin
    rmux = 8'h00;
    if (reg_addr == `SSPT_REG_CTRL) begin
      rmux[`SSPT_CTRL_EN_BIT]    = cfg_q.serial_enable_select;
      rmux[`SSPT_CTRL_RATE_LO]   = cfg_q.rate[0];
      rmux[`SSPT_CTRL_RATE_HI]   = cfg_q.rate[1];
      rmux[`SSPT_CTRL_IRQEN_BIT] = cfg_q.irq_en;
    end else if (reg_addr == `SSPT_REG_STATUS) begin
      rmux[`SSPT_STAT_BUSY_BIT] = busy;
      rmux[`SSPT_STAT_DONE_BIT] = done_q;
      rmux[`SSPT_STAT_SCK_BIT]  = sck_level;
      rmux[7:4]                 = edge_cnt_q;
    end else if (reg_addr == `SSPT_REG_PORT_CFG) begin
      rmux[`SSPT_CFG_OUT_BIT]   = cfg_q.out_cfg;
      rmux[`SSPT_CFG_CLK_BIT]   = cfg_q.clk_cfg;
      rmux[`SSPT_CFG_PHASE_BIT] = cfg_q.clock_phase_select;
    end else if (reg_addr == `SSPT_REG_PORT_DATA) begin
      rmux[`SSPT_DATA_IDLE_BIT] = cfg_q.idle_pol;
    end else if (reg_addr == `SSPT_REG_SHIFT) begin
      rmux = sr_q;
    end else if (reg_addr == `SSPT_REG_LINK) begin
      rmux[0] = si_q;
      rmux[1] = sck_sync_q;
      rmux[2] = so_q;
    end else begin
      rmux = 8'h00;
    end
  end

  logic [7:0] rdata_q;

  // read data only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd ? rmux : 8'h00;
    end
  end

  assign reg_rdata              = rdata_q;
  assign shift_clock_pin_out    = gen_sck;
  assign shift_clock_pin_oe     = sck_oe_q;
  assign port_pin_serial_out    = so_q;
  assign port_pin_serial_out_oe = so_oe_q;
  assign done_irq               = irq_q;

endmodule : sspt_shift_port

// >>> sspt_map.svh
// register map, field positions, reset values and timing counts
// Summary of operation
// [R1] an 8-bit shift register links serial in, serial out and shift clock pins
// [R2] internal shift clock means master mode; external shift clock means slave
// [R3] port active, outputs routed to pins, only while serial enable is one
// [R4] master clock period 2, 4 or 8 instruction cycles from the rate bits
// [R5] setting busy starts shifting; hardware clears busy after eight bits
// [R6] software clearing busy stops shifting at once, leaving a short transfer
// [R7] with its enable set, a full eight-bit shift raises an interrupt request
// [R8] as master the port alone starts transfers by making the shift clock
// [R9] after eight clock pulses the clock stops and busy clears
// [R10] master software sets serial out and clock pins as outputs
// [R11] slave software sets clock pin as input, serial out as output
// [R12] out config 1 drives data, 0 floats; clock config 1 internal, 0 external
// [R13] slave software sets busy at once on entering slave mode
// [R14] software writes the shift register only in the clock idle phase
// [R15] slave software sets busy only in the incoming clock idle phase
// [R16] normal phase samples on rising clock, changes output on falling
// [R17] alternate phase samples on falling clock, changes output on rising
// [R18] port data bit 5 selects clock idle level, 0 low, 1 high
// [R19] port configuration bit 6 selects phase, clear normal, set alternate
// [R20] phase select resets cleared, so normal phase is the default
// [R21] effective phase is phase select exclusive-or idle polarity
// [R22] data moves msb first, received bits enter at the lsb
// [R23] master clock rests at idle level while not busy, even duty cycle
`ifndef SSPT_MAP_SVH
`define SSPT_MAP_SVH

`define SSPT_ADDR_W        4
`define SSPT_REG_CTRL      4'h0
`define SSPT_REG_STATUS    4'h1
`define SSPT_REG_PORT_CFG  4'h2
`define SSPT_REG_PORT_DATA 4'h3
`define SSPT_REG_SHIFT     4'h4
`define SSPT_REG_LINK      4'h5

`define SSPT_CTRL_EN_BIT    0
`define SSPT_CTRL_RATE_LO   1
`define SSPT_CTRL_RATE_HI   2
`define SSPT_CTRL_IRQEN_BIT 3
`define SSPT_STAT_BUSY_BIT  0
`define SSPT_STAT_DONE_BIT  1
`define SSPT_STAT_SCK_BIT   2
`define SSPT_CFG_OUT_BIT    4
`define SSPT_CFG_CLK_BIT    5
`define SSPT_CFG_PHASE_BIT  6
`define SSPT_DATA_IDLE_BIT  5

`define SSPT_SHIFT_RST     8'h00
`define SSPT_EDGES_LAST    4'hf

`define SSPT_CLK_NS        4
`define SSPT_TC_NS         4
`define SSPT_TC_CYC        (`SSPT_TC_NS / `SSPT_CLK_NS)
`define SSPT_PER_R0_TC     2
`define SSPT_PER_R1_TC     4
`define SSPT_PER_R2_TC     8
`define SSPT_HALF_R0       3'((`SSPT_PER_R0_TC * `SSPT_TC_CYC) / 2)
`define SSPT_HALF_R1       3'((`SSPT_PER_R1_TC * `SSPT_TC_CYC) / 2)
`define SSPT_HALF_R2       3'((`SSPT_PER_R2_TC * `SSPT_TC_CYC) / 2)

`endif

// >>> sspt_pkg.sv
// types shared by the serial shift port
package sspt_pkg;

  typedef enum logic {
    SSPT_IDLE  = 1'b0,
    SSPT_SHIFT = 1'b1
  } sspt_state_e;

  typedef struct packed {
    logic       serial_enable_select;
    logic [1:0] rate;
    logic       irq_en;
    logic       out_cfg;
    logic       clk_cfg;
    logic       clock_phase_select;
    logic       idle_pol;
  } sspt_cfg_s;

endpackage : sspt_pkg

// >>> sspt_sck_gen.sv
// master shift clock generator
`timescale 1ns/1ps
`include "sspt_map.svh"

module sspt_sck_gen (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run,
  input  wire logic [1:0] rate,
  input  wire logic       idle_lvl,
  output logic            sck_q,
  output logic            tick
);

  logic [2:0] cnt_q;
  logic [2:0] half_w;

  // [R4] half period per rate
  assign half_w = rate[1] ? `SSPT_HALF_R2 :
                  (rate[0] ? `SSPT_HALF_R1 : `SSPT_HALF_R0);

  // tick marks the cycle in which the clock level flips
  assign tick = run && (cnt_q >= (half_w - 3'h1));

  // [R23] idle level when stopped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
      sck_q <= 1'b0;
    end else if (!run) begin
      cnt_q <= 3'h0;
      sck_q <= idle_lvl;
    end else if (tick) begin
      cnt_q <= 3'h0;
      sck_q <= ~sck_q;
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

endmodule : sspt_sck_gen

// >>> sspt_shift_port_properties.sv
// pin-level checker for the serial shift port
`timescale 1ns/1ps
`include "sspt_map.svh"

module sspt_shift_port_properties (
  input wire logic                    clk,
  input wire logic                    nrst,
  input wire logic [`SSPT_ADDR_W-1:0] reg_addr,
  input wire logic [7:0]              reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    shift_clock_pin_out,
  input wire logic                    shift_clock_pin_oe,
  input wire logic                    port_pin_serial_out_oe,
  input wire logic                    done_irq
);
  logic [7:0] ctrl_q;
  logic [7:0] cfg_q;
  logic [7:0] pdat_q;
  logic [4:0] flips_q;
  logic [2:0] gap_q;
  logic       sck_p_q;
  wire        st_wr = reg_wr && reg_addr == `SSPT_REG_STATUS;
  wire        start = st_wr && reg_wdata[0];
  wire        tog   = shift_clock_pin_out != sck_p_q;
  wire        mst   = ctrl_q[0] && cfg_q[5];
  wire [2:0]  half  = ctrl_q[2] ? 3'h4 : (ctrl_q[1] ? 3'h2 : 3'h1);

  // shadows of the config registers and a flip counter per transfer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q  <= 8'h00;
      cfg_q   <= 8'h00;
      pdat_q  <= 8'h00;
      flips_q <= 5'h10;
      gap_q   <= 3'h0;
      sck_p_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == `SSPT_REG_CTRL) ctrl_q <= reg_wdata;
      if (reg_wr && reg_addr == `SSPT_REG_PORT_CFG) cfg_q <= reg_wdata;
      if (reg_wr && reg_addr == `SSPT_REG_PORT_DATA) pdat_q <= reg_wdata;
      sck_p_q <= shift_clock_pin_out;
      gap_q   <= tog ? 3'h1 : gap_q + 3'(gap_q != 3'h7);
      if (st_wr) flips_q <= reg_wdata[0] ? 5'h00 : 5'h10;
      else flips_q <= flips_q + 5'(tog && flips_q != 5'h10);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  data_oe_a: assert property (!$past(reg_wr) |->
    port_pin_serial_out_oe == (ctrl_q[0] & cfg_q[4]))
    else $error("serial out enable disagrees with config");
  clock_oe_a: assert property (!$past(reg_wr) |->
    shift_clock_pin_oe == (ctrl_q[0] & cfg_q[5]))
    else $error("clock enable disagrees with config");
  half_period_a: assert property (mst && tog && flips_q != 5'h00 &&
    flips_q != 5'h10 |-> gap_q == half)
    else $error("shift clock half period wrong");
  first_edge_a: assert property (start && mst |-> ##[1:10] tog)
    else $error("no shift clock after start");
  stop_after_a: assert property (flips_q == 5'h10 && !reg_wr &&
    shift_clock_pin_out == pdat_q[5] |=> !tog)
    else $error("shift clock moved after sixteen edges");
  idle_level_a: assert property (flips_q == 5'h10 &&
    $past(flips_q) == 5'h10 && $past(pdat_q, 2) == pdat_q
    |-> shift_clock_pin_out == pdat_q[5])
    else $error("shift clock not at idle level");
  irq_after_a: assert property (mst && tog && flips_q == 5'h0f &&
    ctrl_q[3] |-> ##[1:2] done_irq)
    else $error("no interrupt after full byte");
  abort_quiet_a: assert property (st_wr && reg_wdata[1:0] == 2'h2
    |-> ##2 !done_irq [*4])
    else $error("interrupt after software stop");
endmodule : sspt_shift_port_properties

bind sspt_shift_port sspt_shift_port_properties chk (
  .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .shift_clock_pin_out(shift_clock_pin_out),
  .shift_clock_pin_oe(shift_clock_pin_oe),
  .port_pin_serial_out_oe(port_pin_serial_out_oe), .done_irq(done_irq));

// >>> sspt_far_end.sv
// far-side serial peripheral and external clock source
`timescale 1ns/1ps

module sspt_far_end (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       alt,
  input  wire logic       idle,
  input  wire logic       load,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic            sck_gen,
  output logic [7:0]      rx_q
);
  logic [8:0] sh;

  initial begin
    sck_gen = 1'b0;
    rx_q = 8'h00;
    sh = 9'h000;
  end

  // msb preloaded when the first edge samples
  always @(posedge load) sh = (alt ^ idle) ? {1'b0, tx} : {tx, 1'b0};

  // sample one edge, shift the other
  always @(sck) begin
    if (sck ^ alt) rx_q = {rx_q[6:0], mosi};
    else sh = {sh[7:0], ~sh[0]};
  end

  assign miso = sh[8];

  // eight pulses at 32 ns, resting at the idle level
  task automatic pulses;
    // start off the sampling clock edge
    #1 sck_gen = idle;
    repeat (8) begin
      #16 sck_gen = ~idle;
      #16 sck_gen = idle;
    end
  endtask : pulses
endmodule : sspt_far_end

// >>> sspt_shift_port_bench.sv
// self-checking bench for the serial shift port
`timescale 1ns/1ps
`include "sspt_map.svh"

module sspt_shift_port_bench;
  logic                    clk, nrst, reg_wr, reg_rd, load, alt, idle;
  logic [`SSPT_ADDR_W-1:0] reg_addr;
  logic [7:0]              reg_wdata, reg_rdata, tx, rx, v;
  logic                    sck_o, sck_oe, so, so_oe, irq, si, sck_g;
  wire                     sck_w = sck_oe ? sck_o : sck_g;
  int                      errors, comparisons;

  sspt_shift_port uut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .serial_in(si), .shift_clock_pin_in(sck_w),
    .shift_clock_pin_out(sck_o), .shift_clock_pin_oe(sck_oe),
    .port_pin_serial_out(so), .port_pin_serial_out_oe(so_oe),
    .done_irq(irq));
  sspt_far_end far (.sck(sck_w), .mosi(so_oe ? so : 1'b1), .alt(alt),
    .idle(idle), .load(load), .tx(tx), .miso(si), .sck_gen(sck_g),
    .rx_q(rx));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd

  task automatic go(input logic [7:0] d);
    wr(`SSPT_REG_SHIFT, d);
    load = 1'b1;
    #1 load = 1'b0;
    wr(`SSPT_REG_STATUS, 8'h01);
  endtask : go

  task automatic wait_idle;
    v = 8'h01;
    for (int n = 0; n < 200 && v[0] !== 1'b0; n++) rd(`SSPT_REG_STATUS);
    chk(v & 8'h01, 8'h00);
  endtask : wait_idle

  task automatic stop_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    #100000;
    errors++;
    stop_test();
  end

  initial begin
    {nrst, reg_wr, reg_rd, load, alt, idle} = 6'h00;
    {reg_addr, reg_wdata, tx} = 20'h00000;
    errors = 0;
    comparisons = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`SSPT_REG_PORT_CFG);
    chk(v, 8'h00);
    chk(8'({sck_oe, so_oe, irq}), 8'h00);
    // rate settings 0 to 3, each with one of the four phase and idle pairings, master mode
    for (int i = 0; i < 4; i++) begin
      idle = i[1];
      alt = i[0] ^ i[1];
      tx = 8'h96 ^ 8'(i);
      wr(`SSPT_REG_PORT_DATA, {2'h0, idle, 5'h00});
      wr(`SSPT_REG_PORT_CFG, {1'b0, i[0], 6'h30});
      wr(`SSPT_REG_CTRL, {5'h01, 2'(i), 1'b1});
      go(8'h5a - 8'(i));
      wait_idle();
      chk(rx, 8'h5a - 8'(i));
      rd(`SSPT_REG_SHIFT);
      chk(v, tx);
      chk(8'(irq), 8'h01);
      wr(`SSPT_REG_STATUS, 8'h02);
    end
    // software stop in mid-byte
    go(8'hc3);
    repeat (12) @(posedge clk);
    wr(`SSPT_REG_STATUS, 8'h02);
    rd(`SSPT_REG_STATUS);
    chk(v & 8'h03, 8'h00);
    chk(8'(irq), 8'h00);
    // slave: busy set at once while the incoming clock idles
    idle = 1'b0;
    alt = 1'b0;
    tx = 8'ha5;
    wr(`SSPT_REG_PORT_DATA, 8'h00);
    wr(`SSPT_REG_PORT_CFG, 8'h10);
    go(8'h3c);
    chk(8'({sck_oe, so_oe}), 8'h01);
    far.pulses();
    wait_idle();
    chk(rx, 8'h3c);
    rd(`SSPT_REG_SHIFT);
    chk(v, 8'ha5);
    wr(`SSPT_REG_PORT_CFG, 8'h20);
    rd(4'hf);
    chk(v, 8'h00);
    chk(8'({sck_oe, so_oe}), 8'h02);
    wr(`SSPT_REG_CTRL, 8'h00);
    rd(`SSPT_REG_CTRL);
    chk(v, 8'h00);
    chk(8'({sck_oe, so_oe}), 8'h00);
    stop_test();
  end
endmodule : sspt_shift_port_bench
